/* File: pss_checker.sv */
// concurrent checks on the power-save controller ports
`timescale 1ns/1ps
`default_nettype none
module pss_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [pss_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pss_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic nmiReq,
  input wire logic inNmiService,
  input wire pss_pkg::pss_clk_s clkEn,
  input wire pss_pkg::pss_wake_s wake
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_reset_clocks: assert property ($rose(rst_b) |-> clkEn == 4'hF)
    else $error("clocks not all running at reset release");
  a_entry_gate: assert property (regWrite && regAddr == pss_pkg::MODE_OFF
    && regWdata[1:0] != 2'h0 && clkEn.cpu && !nmiReq |-> ##[1:3] !clkEn.cpu)
    else $error("standby write did not stop the cpu clock");
  a_stay_run: assert property (regWrite && regAddr == pss_pkg::MODE_OFF
    && regWdata[1:0] == 2'h0 && clkEn.cpu |=> clkEn.cpu [*3])
    else $error("run mode write stopped the cpu clock");
  a_osc_pll: assert property (clkEn.osc |-> clkEn.pll)
    else $error("oscillator on without pll");
  a_cpu_periph: assert property (clkEn.cpu |-> clkEn.periph)
    else $error("cpu clock on without peripheral clock");
  a_stab_hold: assert property ($rose(clkEn.pll) && !clkEn.cpu
    |=> !clkEn.cpu [*3] ##[1:1000] clkEn.cpu)
    else $error("stabilisation wait cut short or endless");
  a_halt_nmi: assert property (!clkEn.cpu && clkEn.periph && nmiReq
    && !inNmiService |-> ##[1:2] wake.nmiAck)
    else $error("nmi did not end halt");
  a_pend_resume: assert property (wake.pending |-> wake.resume
    && !wake.intAck && !wake.nmiAck)
    else $error("pending wake also acknowledged");
  a_wake_pulse: assert property (wake != 4'h0 |-> clkEn.cpu ##1 wake == 4'h0)
    else $error("wake not a single pulse with cpu running");
endmodule

bind pss_power_save pss_checker pss_checker_inst (.clock(clock), .rst_b(rst_b),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .nmiReq(nmiReq),
  .inNmiService(inNmiService), .clkEn(clkEn), .wake(wake));
`default_nettype wire

/* File: pss_clk_table.sv */
// decode of clock source and power-save state into clock enables
`timescale 1ns/1ps
`default_nettype none
module pss_clk_table (
  input wire pss_pkg::pss_state_e state,
  input wire logic pllMode,
  input wire logic extClock,
  output pss_pkg::pss_clk_s clk
);

  // ----------------------------------------
  // table
  // ----------------------------------------
  always_comb begin
    clk = '0;
    case (state)
      pss_pkg::ST_RUN: begin
        clk.periph = 1'b1;
        clk.cpu = 1'b1;
      end
      pss_pkg::ST_HALT: begin
        clk.periph = 1'b1;
      end
      default: begin
        clk.periph = 1'b0;
      end
    endcase
    if (pllMode) begin
      clk.pll = (state != pss_pkg::ST_STOP);
      // pll idles in IDLE only when fed from the external clock
      if (extClock && state == pss_pkg::ST_IDLE) begin
        clk.pll = 1'b0;
      end
      clk.osc = !extClock && (state != pss_pkg::ST_STOP);
    end
  end

endmodule
`default_nettype wire

/* File: pss_irq_model.sv */
// interrupt controller model: request levels held until the core answers
`timescale 1ns/1ps
`default_nettype none
module pss_irq_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fire,
  input wire logic fireNmi,
  input wire logic [3:0] fireLine,
  input wire pss_pkg::pss_wake_s wake,
  output logic nmiReq,
  output logic [15:0] edgeInterruptInput
);
  // no timeout: a request nobody answers stays up, as on real silicon
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nmiReq <= 1'b0;
      edgeInterruptInput <= 16'h0000;
    end else if (fire) begin
      nmiReq <= fireNmi;
      edgeInterruptInput <= fireNmi ? 16'h0000 : 16'h0001 << fireLine;
    end else if (wake != 4'h0) begin
      nmiReq <= 1'b0;
      edgeInterruptInput <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: pss_pkg.sv */
// package: constants and carriers of the power-save clock controller
package pss_pkg;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] CTRL_OFF = 4'h1;
  localparam logic [3:0] CLKC_OFF = 4'h2;
  localparam logic [3:0] STAT_OFF = 4'h3;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int MREL_BIT = 0;
  localparam int NREL_BIT = 1;
  localparam int ECS_BIT = 0;

  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_IDLE = 2'h2;
  localparam logic [1:0] MODE_STOP = 2'h3;

  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic ECS_RST = 1'b0;
  localparam logic PIN_RST = 1'b0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 8;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALT = 3'b001,
    ST_IDLE = 3'b010,
    ST_STOP = 3'b011,
    ST_STAB = 3'b100
  } pss_state_e;

  typedef struct packed {
    logic osc;
    logic pll;
    logic periph;
    logic cpu;
  } pss_clk_s;

  typedef struct packed {
    logic nmiAck;
    logic intAck;
    logic resume;
    logic pending;
  } pss_wake_s;

  typedef struct packed {
    logic meta;
    logic sync;
  } pss_sync_s;

endpackage

/* File: pss_power_save.sv */
// power-save clock gating and software STOP release controller
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - PLL mode with resonator: HALT stops the CPU clock, IDLE also peripherals, STOP all.
// - PLL mode with external clock keeps the oscillator off; PLL runs in run, HALT and the stabilization wait only.
// - Direct mode never runs the PLL; peripherals clock in run and HALT, CPU in run only.
// - A low clock-select pin means PLL mode; select bit 0 resonator, 1 external clock.
// - STOP ends on a non-maskable request, an unmasked edge request or the reset pin.
// - Leaving STOP in PLL mode waits the stabilization time before clocks return.
// - Requests release STOP only if both release masks were 0 at entry.
// - Level-configured interrupt inputs never release a standby mode.
// - A qualifying request releases STOP whatever its priority.
// - NMI wake branches outside an NMI routine; maskable wake branches or resumes if enabled, else resumes.
// - STOP entered in a maskable routine: a lower request ends STOP but stays pending.
// - STOP entered in a maskable routine: a non-maskable request, or a higher one while interrupts are enabled, is acknowledged.
// - STOP entered in an NMI routine: any release leaves the request pending.
// - An NMI wake uses the ordinary NMI path, and the status register records it as the last wake.
// - A reset pin release acts exactly as an ordinary reset.
module pss_power_save #(
  parameter int NUM_INT = 16,
  parameter int PRIO_W = 3,
  parameter int STAB_CYCLES = pss_pkg::STAB_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [pss_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pss_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [pss_pkg::DATA_W-1:0] regRdata,
  input wire logic pllDirectSelectPin,
  input wire logic nmiReq,
  input wire logic [NUM_INT-1:0] edgeInterruptInput,
  input wire logic [NUM_INT-1:0] intMasked,
  input wire logic [NUM_INT-1:0] intEdgeMode,
  input wire logic [NUM_INT*PRIO_W-1:0] intPrio,
  input wire logic intEnabled,
  input wire logic inService,
  input wire logic inNmiService,
  input wire logic [PRIO_W-1:0] servicePrio,
  output pss_pkg::pss_clk_s clkEn,
  output pss_pkg::pss_wake_s wake
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (NUM_INT < 1) begin : g_chk_int
    $error("NUM_INT must be at least 1");
  end
  if (PRIO_W < 1) begin : g_chk_prio
    $error("PRIO_W must be at least 1");
  end
  if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << pss_pkg::CNT_W)) begin : g_chk_stab
    $error("STAB_CYCLES out of counter range");
  end

  localparam logic [pss_pkg::CNT_W-1:0] STAB_LOAD =
    pss_pkg::CNT_W'(STAB_CYCLES - 1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pss_pkg::pss_state_e state;
    logic [1:0] mode;
    logic modeReq;
    logic maskableReleaseMask;
    logic nonmaskableReleaseMask;
    logic extClock;
    logic pllMode;
    logic stopIrqOk;
    logic [pss_pkg::CNT_W-1:0] cnt;
    pss_pkg::pss_wake_s hold;
    pss_pkg::pss_wake_s wake;
    pss_pkg::pss_wake_s lastWake;
    pss_pkg::pss_clk_s clk;
    logic [pss_pkg::DATA_W-1:0] rdata;
  } pss_core_s;

  pss_core_s s;
  pss_core_s next_s;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic selSync;

  pss_sync2 u_sel_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pinIn(pllDirectSelectPin),
    .pinSync(selSync)
  );

  // ----------------------------------------
  // wake qualification per input
  // ----------------------------------------
  logic [NUM_INT-1:0] qual;
  logic [NUM_INT-1:0] higher;

  for (genvar i = 0; i < NUM_INT; i++) begin : g_qual
    assign qual[i] = edgeInterruptInput[i] && !intMasked[i] && intEdgeMode[i];
    // lower number ranks higher
    assign higher[i] = intPrio[i*PRIO_W +: PRIO_W] < servicePrio;
  end

  logic anyInt;
  logic anyHigher;
  logic anyWake;

  assign anyInt = |qual;
  assign anyHigher = |(qual & higher);
  assign anyWake = nmiReq || anyInt;

  // ----------------------------------------
  // outcome of a release
  // ----------------------------------------
  pss_pkg::pss_wake_s dec;

  always_comb begin
    dec = '0;
    if (nmiReq) begin
      if (inNmiService) begin
        dec.pending = 1'b1;
        dec.resume = 1'b1;
      end else begin
        dec.nmiAck = 1'b1;
      end
    end else if (inNmiService) begin
      dec.pending = 1'b1;
      dec.resume = 1'b1;
    end else if (inService && !anyHigher) begin
      dec.pending = 1'b1;
      dec.resume = 1'b1;
    end else if (intEnabled) begin
      dec.intAck = 1'b1;
    end else begin
      dec.resume = 1'b1;
    end
  end

  // ----------------------------------------
  // clock table for the next state
  // ----------------------------------------
  pss_pkg::pss_clk_s nextClk;

  pss_clk_table u_table (
    .state(next_s.state),
    .pllMode(next_s.pllMode),
    .extClock(next_s.extClock),
    .clk(nextClk)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.wake = '0;
    next_s.rdata = '0;

    // register reads
    if (regRead) begin
      case (regAddr)
        pss_pkg::MODE_OFF: begin
          next_s.rdata[pss_pkg::MODE_MSB:pss_pkg::MODE_LSB] = s.mode;
        end
        pss_pkg::CTRL_OFF: begin
          next_s.rdata[pss_pkg::MREL_BIT] = s.maskableReleaseMask;
          next_s.rdata[pss_pkg::NREL_BIT] = s.nonmaskableReleaseMask;
        end
        pss_pkg::CLKC_OFF: begin
          next_s.rdata[pss_pkg::ECS_BIT] = s.extClock;
        end
        pss_pkg::STAT_OFF: begin
          next_s.rdata = {s.lastWake, s.pllMode, s.state};
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end

    // register writes; a mode write only arms the entry
    next_s.modeReq = 1'b0;
    if (regWrite) begin
      case (regAddr)
        pss_pkg::MODE_OFF: begin
          next_s.mode = regWdata[pss_pkg::MODE_MSB:pss_pkg::MODE_LSB];
          next_s.modeReq = 1'b1;
        end
        pss_pkg::CTRL_OFF: begin
          next_s.maskableReleaseMask = regWdata[pss_pkg::MREL_BIT];
          next_s.nonmaskableReleaseMask = regWdata[pss_pkg::NREL_BIT];
        end
        pss_pkg::CLKC_OFF: begin
          next_s.extClock = regWdata[pss_pkg::ECS_BIT];
        end
        default: begin
          next_s.modeReq = 1'b0;
        end
      endcase
    end

    case (s.state)
      pss_pkg::ST_RUN: begin
        // source follows the pin only while running, never mid-standby
        next_s.pllMode = !selSync;
        if (s.modeReq) begin
          case (s.mode)
            pss_pkg::MODE_HALT: begin
              next_s.state = pss_pkg::ST_HALT;
            end
            pss_pkg::MODE_IDLE: begin
              next_s.state = pss_pkg::ST_IDLE;
            end
            pss_pkg::MODE_STOP: begin
              next_s.state = pss_pkg::ST_STOP;
              // masks are judged as they stand at entry
              next_s.stopIrqOk = !s.maskableReleaseMask && !s.nonmaskableReleaseMask;
            end
            default: begin
              next_s.state = pss_pkg::ST_RUN;
            end
          endcase
        end
      end
      pss_pkg::ST_HALT, pss_pkg::ST_IDLE: begin
        if (anyWake) begin
          next_s.state = pss_pkg::ST_RUN;
          next_s.wake = dec;
          next_s.lastWake = dec;
        end
      end
      pss_pkg::ST_STOP: begin
        if (s.stopIrqOk && anyWake) begin
          next_s.hold = dec;
          if (s.pllMode) begin
            next_s.state = pss_pkg::ST_STAB;
            next_s.cnt = STAB_LOAD;
          end else begin
            next_s.state = pss_pkg::ST_RUN;
            next_s.wake = dec;
            next_s.lastWake = dec;
          end
        end
      end
      pss_pkg::ST_STAB: begin
        // requests during the wait are left to the interrupt controller
        if (s.cnt == '0) begin
          next_s.state = pss_pkg::ST_RUN;
          next_s.wake = s.hold;
          next_s.lastWake = s.hold;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      default: begin
        next_s.state = pss_pkg::ST_RUN;
      end
    endcase

    // stabilization keeps the pll up, and the oscillator unless on external clock, but gates the cpu and peripheral clocks
    if (next_s.state == pss_pkg::ST_STAB) begin
      next_s.clk = '0;
      next_s.clk.osc = !next_s.extClock;
      next_s.clk.pll = 1'b1;
    end else begin
      next_s.clk = nextClk;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s.state <= pss_pkg::ST_RUN;
      s.mode <= pss_pkg::MODE_RST;
      s.modeReq <= 1'b0;
      s.maskableReleaseMask <= pss_pkg::CTRL_RST[pss_pkg::MREL_BIT];
      s.nonmaskableReleaseMask <= pss_pkg::CTRL_RST[pss_pkg::NREL_BIT];
      s.extClock <= pss_pkg::ECS_RST;
      s.pllMode <= 1'b1;
      s.stopIrqOk <= 1'b0;
      s.cnt <= '0;
      s.hold <= '0;
      s.wake <= '0;
      s.lastWake <= '0;
      // reset comes up in PLL mode with the resonator running
      s.clk <= 4'hF;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = s.rdata;
  assign clkEn = s.clk;
  assign wake = s.wake;

endmodule
`default_nettype wire

/* File: pss_sync2.sv */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module pss_sync2 (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic pinSync
);

  pss_pkg::pss_sync_s s;
  pss_pkg::pss_sync_s next_s;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  always_comb begin
    next_s.meta = pinIn;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= {pss_pkg::PIN_RST, pss_pkg::PIN_RST};
    end else begin
      s <= next_s;
    end
  end

  assign pinSync = s.sync;

endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking testbench of the power-save controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int STAB = 4;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic pin = 1'b0;
  logic nmiReq;
  logic [15:0] edgeIn;
  logic [15:0] intMasked = 16'h0000;
  logic [15:0] intEdgeMode = 16'hFFFF;
  logic [47:0] intPrio = 48'h0;
  logic intEnabled = 1'b0;
  logic inService = 1'b0;
  logic inNmiService = 1'b0;
  logic [2:0] servicePrio = 3'h3;
  pss_pkg::pss_clk_s clkEn;
  pss_pkg::pss_wake_s wake;
  logic fire = 1'b0;
  logic fireNmi = 1'b0;
  logic [3:0] fireLine = 4'h0;
  logic ext = 1'b0;
  logic stopFlag = 1'b0;
  logic [31:0] seed = 32'hF4C89B4D;
  logic [5:0] prioCases [5] = '{6'h25, 6'h21, 6'h28, 6'h18, 6'h12};
  int miscompares = 0;
  int num_checks = 0;

  always #4 clock = ~clock;

  pss_power_save #(.STAB_CYCLES(STAB)) pss_power_save_inst (.clock(clock), .rst_b(rst_b),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pllDirectSelectPin(pin), .nmiReq(nmiReq),
    .edgeInterruptInput(edgeIn), .intMasked(intMasked), .intEdgeMode(intEdgeMode),
    .intPrio(intPrio), .intEnabled(intEnabled), .inService(inService),
    .inNmiService(inNmiService), .servicePrio(servicePrio), .clkEn(clkEn), .wake(wake));

  pss_irq_model pss_irq_model_inst (.clock(clock), .rst_b(rst_b), .fire(fire),
    .fireNmi(fireNmi), .fireLine(fireLine), .wake(wake), .nmiReq(nmiReq),
    .edgeInterruptInput(edgeIn));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] expClk(logic [1:0] m, logic pll, logic e);
    logic osc;
    osc = pll && !e;
    case (m)
      2'h0: expClk = {4'h0, osc, pll, 2'b11};
      2'h1: expClk = {4'h0, osc, pll, 2'b10};
      2'h2: expClk = {4'h0, osc, osc, 2'b00};
      default: expClk = 8'h00;
    endcase
  endfunction

  // equal priority counts as not higher, so it stays pending
  function automatic logic [7:0] expWake(logic nmi, logic [2:0] p);
    if (inNmiService || (!nmi && inService && p >= servicePrio)) expWake = 8'h03;
    else if (nmi) expWake = 8'h08;
    else expWake = intEnabled ? 8'h04 : 8'h02;
  endfunction

  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask

  task automatic doReset();
    rst_b <= 1'b0;
    ext = 1'b0;
    repeat (12) @(posedge clock);
    #1 chk(8'(clkEn), 8'h0F);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic standby(input logic [1:0] m, input logic nmi, input logic go);
    int k;
    stopFlag <= (m == 2'h3);
    wr(4'h0, {6'h00, m});
    repeat (2) @(posedge clock);
    #1 chk(8'(clkEn), expClk(m, !pin, ext));
    fireNmi <= nmi;
    fireLine <= 4'(rnd());
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    for (k = 0; k < (go ? 300 : 20) && wake === 4'h0; k++) begin
      @(posedge clock);
      #1;
    end
    if (go) begin
      chk(8'(wake), expWake(nmi, intPrio[2:0]));
      chk(8'(clkEn), expClk(2'h0, !pin, ext));
      if (m == 2'h3 && !pin) chk(8'(k >= STAB), 8'h01);
      rd(4'h3, {4'(expWake(nmi, intPrio[2:0])), !pin, 3'h0});
      if (k == 300) tally_and_finish();
    end else begin
      chk(8'(wake), 8'h00);
      doReset();
    end
  endtask

  initial begin
    doReset();
    for (int a = 0; a < 3; a++) rd(4'(a), 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h0, 8'h00);
    repeat (3) @(posedge clock);
    #1 chk(8'(clkEn), 8'h0F);
    for (int i = 0; i < 12; i++) begin
      pin <= (i >= 6);
      ext = (i % 6 >= 3);
      intEnabled <= 1'(rnd());
      wr(4'h2, {7'h00, ext});
      repeat (3) @(posedge clock);
      standby(2'(i % 3 + 1), 1'(rnd()), 1'b1);
    end
    for (int j = 0; j < 5; j++) begin
      {inService, inNmiService} <= prioCases[j][5:4];
      intPrio <= {16{prioCases[j][2:0]}};
      intEnabled <= 1'(rnd());
      pin <= 1'(rnd());
      repeat (3) @(posedge clock);
      standby(2'h3, prioCases[j][3], 1'b1);
    end
    {inService, inNmiService} <= 2'b00;
    for (int b = 1; b < 3; b++) begin
      wr(4'h1, 8'(b));
      standby(2'h3, 1'(rnd()), 1'b0);
    end
    intEdgeMode <= 16'h0000;
    standby(2'h2, 1'b0, 1'b0);
    intEdgeMode <= 16'hFFFF;
    intMasked <= 16'hFFFF;
    standby(2'h1, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
